/* verilog/fes_defines.svh */
// Opcodes, field positions, reset values and timing counts of the erase and suspend sequencer
`ifndef FES_DEFINES_SVH
`define FES_DEFINES_SVH

`define FES_OP_WRITE_ENABLE        8'h06
`define FES_OP_REG_WRITE           8'h01
`define FES_OP_CLEAR_STATUS        8'h30
`define FES_OP_BANK_ACCESS         8'hb9
`define FES_OP_PERSIST_LOCK_ERASE  8'he4
`define FES_OP_SECTOR_WIPE         8'hd8
`define FES_OP_SECTOR_WIPE_LONG    8'hdc
`define FES_OP_ARRAY_WIPE_A        8'h60
`define FES_OP_ARRAY_WIPE_B        8'hc7
`define FES_OP_PAGE_PROG           8'h02
`define FES_OP_PAGE_PROG_LONG      8'h12
`define FES_OP_PROGRAM_PAUSE       8'h85
`define FES_OP_PROGRAM_CONTINUE    8'h8a
`define FES_OP_ERASE_PAUSE         8'h75
`define FES_OP_ERASE_CONTINUE      8'h7a

`define FES_OPCODE_BITS    6'h08
`define FES_REG_WRITE_BITS 6'h10
`define FES_ADDR24_END     6'h20
`define FES_ADDR32_END     6'h28
`define FES_DATA_BITS      6'h08
`define FES_SECT_MSB       25
`define FES_SECT_LSB       18
`define FES_LAST_SECTOR    8'hff
`define FES_BANK_RESET     8'h00

`define FES_CLK_MHZ                20
`define FES_PROG_PAUSE_LAT_US      40
`define FES_PROG_PAUSE_LAT_CYC     (`FES_PROG_PAUSE_LAT_US * `FES_CLK_MHZ)
`define FES_ERASE_PAUSE_LAT_US     45
`define FES_ERASE_PAUSE_LAT_CYC    (`FES_ERASE_PAUSE_LAT_US * `FES_CLK_MHZ)
`define FES_SECTOR_WIPE_US         1000
`define FES_SECTOR_WIPE_CYC        (`FES_SECTOR_WIPE_US * `FES_CLK_MHZ)
`define FES_PAGE_PROG_US           500
`define FES_PAGE_PROG_CYC          (`FES_PAGE_PROG_US * `FES_CLK_MHZ)

`endif

/* verilog/fes_pkg.sv */
// Types shared by the erase and suspend sequencer
package fes_pkg;

    typedef enum logic [2:0] {
        FES_IDLE   = 3'b000,
        FES_ERASE  = 3'b001,
        FES_E_PEND = 3'b011,
        FES_E_SUSP = 3'b010,
        FES_PROG   = 3'b110,
        FES_P_PEND = 3'b111,
        FES_P_SUSP = 3'b101
    } fes_state_t;

    typedef struct packed {
        logic [7:0]  op;
        logic [31:0] addr;
        logic [5:0]  bits;
        logic [7:0]  data;
    } fes_frame_t;

    typedef struct packed {
        logic erase_err;
        logic prog_err;
        logic erase_paused;
        logic prog_paused;
        logic write_enable_latch;
        logic write_in_progress_flag;
    } fes_status_t;

endpackage : fes_pkg

/* verilog/fes_timer.sv */
// Loadable countdown used for operation times and pause latencies
`timescale 1ns/1ps
`default_nettype none
module fes_timer (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_load,
    input  wire logic [19:0] i_value,
    input  wire logic        i_run,
    output logic             o_expired
);
    logic [19:0] count_reg;

    // Frozen while not running, so a paused operation keeps its remaining time
    assign o_expired = i_run && (count_reg == 20'h00001);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count_reg <= 20'h00000;
        end else if (i_load) begin
            count_reg <= i_value;
        end else if (i_run && count_reg != 20'h00000) begin
            count_reg <= count_reg - 20'h00001;
        end
    end
endmodule : fes_timer
`default_nettype wire

/* verilog/fes_sequencer.sv */
// Erase, program pause and resume command sequencer behind the serial pins
`timescale 1ns/1ps
`default_nettype none
`include "fes_defines.svh"
module fes_sequencer import fes_pkg::*; #(
    parameter int unsigned ERASE_CYCLES = `FES_SECTOR_WIPE_CYC,
    parameter int unsigned PROG_CYCLES  = `FES_PAGE_PROG_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_cs_n,
    input  wire logic       i_sck,
    input  wire logic       i_si,
    input  wire logic       i_long_address_select,
    input  wire logic [2:0] i_block_protect,
    input  wire logic       i_block_protect_hit,
    input  wire logic       i_sector_lock_hit,
    output fes_status_t     o_status,
    output logic [7:0]      o_query_sector,
    output logic            o_erase_run,
    output logic            o_erase_all,
    output logic [7:0]      o_erase_sector,
    output logic            o_prog_run,
    output logic [31:0]     o_prog_addr,
    output logic [7:0]      o_bank_addr,
    output logic            o_reg_write,
    output logic [7:0]      o_reg_data,
    output logic            o_lock_erase
);
    localparam int ESL_BOUND = `FES_ERASE_PAUSE_LAT_CYC;

    fes_state_t  state_reg;
    fes_state_t  state_next;
    fes_frame_t  frm_reg;
    logic        frm_valid_reg;
    logic        sck_q_reg;
    logic        cs_q_reg;
    logic [31:0] shift_reg;
    logic [5:0]  bits_reg;
    logic [7:0]  op_reg;
    logic [31:0] addr_reg;
    logic        write_enable_latch_reg;
    logic        es_reg;
    logic        bank_armed_reg;
    logic        erase_chk_reg;
    logic [7:0]  esector_next;
    logic        erase_exp;
    logic        prog_exp;
    logic        lat_exp;
    fes_status_t status_next;

    // Serial front end; pins are synchronous, so edges come from one stored sample
    wire        sck_rise = i_sck & ~sck_q_reg & ~i_cs_n;
    wire        cs_rise  = i_cs_n & ~cs_q_reg;
    wire        cs_fall  = ~i_cs_n & cs_q_reg;
    wire [31:0] shift_in = {shift_reg[30:0], i_si};
    wire        long_op  = (op_reg == `FES_OP_SECTOR_WIPE_LONG) || (op_reg == `FES_OP_PAGE_PROG_LONG)
                           || i_long_address_select;
    wire [5:0]  addr_end = long_op ? `FES_ADDR32_END : `FES_ADDR24_END;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sck_q_reg <= 1'b0;
            cs_q_reg  <= 1'b1;
            shift_reg <= 32'h00000000;
            bits_reg  <= 6'h00;
            op_reg    <= 8'h00;
            addr_reg  <= 32'h00000000;
        end else begin
            sck_q_reg <= i_sck;
            cs_q_reg  <= i_cs_n;
            if (cs_fall) begin
                bits_reg <= 6'h00;
            end else if (sck_rise && bits_reg != 6'h3f) begin
                bits_reg <= bits_reg + 6'h01;
            end
            if (sck_rise) begin
                shift_reg <= shift_in;
            end
            if (sck_rise && bits_reg == `FES_OPCODE_BITS - 6'h01) begin
                op_reg <= shift_in[7:0];
            end
            if (sck_rise && bits_reg == addr_end - 6'h01) begin
                addr_reg <= long_op ? shift_in : {8'h00, shift_in[23:0]};
            end
        end
    end

    // Whole frame is judged one cycle after chip select rises
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            frm_valid_reg <= 1'b0;
            frm_reg       <= '0;
        end else begin
            frm_valid_reg <= cs_rise;
            if (cs_rise) begin
                frm_reg.op   <= op_reg;
                frm_reg.addr <= addr_reg;
                frm_reg.bits <= bits_reg;
                frm_reg.data <= shift_reg[7:0];
            end
        end
    end

    // Command decode
    wire       st_idle  = state_reg == FES_IDLE;
    wire       st_erase = state_reg == FES_ERASE;
    wire       st_epend = state_reg == FES_E_PEND;
    wire       st_esusp = state_reg == FES_E_SUSP;
    wire       st_prog  = state_reg == FES_PROG;
    wire       st_ppend = state_reg == FES_P_PEND;
    wire       st_psusp = state_reg == FES_P_SUSP;
    wire       f_long   = (frm_reg.op == `FES_OP_SECTOR_WIPE_LONG) || (frm_reg.op == `FES_OP_PAGE_PROG_LONG)
                          || i_long_address_select;
    wire [5:0] f_end    = f_long ? `FES_ADDR32_END : `FES_ADDR24_END;
    wire       f_exact8 = frm_valid_reg && frm_reg.bits == `FES_OPCODE_BITS;
    wire       prot_hit = i_block_protect_hit | i_sector_lock_hit;

    // Pending states take no command at all; status reads live outside this block
    wire open_state = st_idle | st_esusp;
    wire write_enable_cmd_go  = f_exact8 && frm_reg.op == `FES_OP_WRITE_ENABLE && open_state;
    wire clsr_go  = f_exact8 && frm_reg.op == `FES_OP_CLEAR_STATUS && open_state;
    wire se_try   = frm_valid_reg && frm_reg.bits == f_end && st_idle && write_enable_latch_reg
                    && (frm_reg.op == `FES_OP_SECTOR_WIPE || frm_reg.op == `FES_OP_SECTOR_WIPE_LONG);
    wire se_go    = se_try && !prot_hit;
    wire se_fail  = se_try && prot_hit;
    wire be_try   = f_exact8 && st_idle && write_enable_latch_reg
                    && (frm_reg.op == `FES_OP_ARRAY_WIPE_A || frm_reg.op == `FES_OP_ARRAY_WIPE_B);
    wire be_go    = be_try && i_block_protect == 3'h0;
    wire pp_try   = frm_valid_reg && frm_reg.bits >= f_end + `FES_DATA_BITS && open_state
                    && write_enable_latch_reg
                    && (frm_reg.op == `FES_OP_PAGE_PROG || frm_reg.op == `FES_OP_PAGE_PROG_LONG);
    wire pp_fail  = pp_try && ((st_esusp && o_query_sector == o_erase_sector) || prot_hit);
    wire pp_go    = pp_try && !pp_fail;
    wire program_pause_cmd_go  = f_exact8 && frm_reg.op == `FES_OP_PROGRAM_PAUSE && st_prog;
    wire program_continue_cmd_go  = f_exact8 && frm_reg.op == `FES_OP_PROGRAM_CONTINUE && st_psusp;
    wire erase_pause_cmd_go  = f_exact8 && frm_reg.op == `FES_OP_ERASE_PAUSE && st_erase && !o_erase_all;
    wire erase_continue_cmd_go  = f_exact8 && frm_reg.op == `FES_OP_ERASE_CONTINUE && st_esusp;
    wire bank_access_cmd_cmd = f_exact8 && frm_reg.op == `FES_OP_BANK_ACCESS && (open_state | st_psusp);
    wire wrr_cmd  = frm_valid_reg && frm_reg.op == `FES_OP_REG_WRITE && frm_reg.bits == `FES_REG_WRITE_BITS;
    wire bank_go  = wrr_cmd && bank_armed_reg;
    wire regw_go  = wrr_cmd && !bank_armed_reg && st_idle && write_enable_latch_reg;
    wire ppbe_go  = f_exact8 && frm_reg.op == `FES_OP_PERSIST_LOCK_ERASE && st_idle && write_enable_latch_reg;
    wire [7:0] f_sector = frm_reg.addr[`FES_SECT_MSB:`FES_SECT_LSB];

    // Array erase walks every sector; locked ones are passed over without error
    wire erase_live = st_erase | st_epend;
    wire bulk_last  = o_erase_sector == `FES_LAST_SECTOR;
    wire bulk_skip  = o_erase_all && erase_chk_reg && i_sector_lock_hit && erase_live;
    wire sect_done  = erase_exp | bulk_skip;
    wire erase_done = sect_done && (!o_erase_all || bulk_last);
    wire bulk_adv   = sect_done && o_erase_all && !bulk_last;
    wire prog_live  = st_prog | st_ppend;

    fes_timer u_erase_timer (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_load    (se_go | be_go | bulk_adv),
        .i_value   (20'(ERASE_CYCLES)),
        .i_run     (erase_live),
        .o_expired (erase_exp)
    );

    fes_timer u_prog_timer (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_load    (pp_go),
        .i_value   (20'(PROG_CYCLES)),
        .i_run     (prog_live),
        .o_expired (prog_exp)
    );

    fes_timer u_pause_timer (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_load    (program_pause_cmd_go | erase_pause_cmd_go),
        .i_value   (program_pause_cmd_go ? 20'(`FES_PROG_PAUSE_LAT_CYC) : 20'(`FES_ERASE_PAUSE_LAT_CYC)),
        .i_run     (st_ppend | st_epend),
        .o_expired (lat_exp)
    );

    // Completion beats the pause timer, so a finished operation never reads as paused
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            FES_IDLE: begin
                if (se_go || be_go) begin
                    state_next = FES_ERASE;
                end else if (pp_go) begin
                    state_next = FES_PROG;
                end
            end
            FES_ERASE: begin
                if (erase_done) begin
                    state_next = FES_IDLE;
                end else if (erase_pause_cmd_go) begin
                    state_next = FES_E_PEND;
                end
            end
            FES_E_PEND: begin
                if (erase_done) begin
                    state_next = FES_IDLE;
                end else if (lat_exp) begin
                    state_next = FES_E_SUSP;
                end
            end
            FES_E_SUSP: begin
                if (erase_continue_cmd_go) begin
                    state_next = FES_ERASE;
                end else if (pp_go) begin
                    state_next = FES_PROG;
                end
            end
            FES_PROG: begin
                if (prog_exp) begin
                    state_next = es_reg ? FES_E_SUSP : FES_IDLE;
                end else if (program_pause_cmd_go) begin
                    state_next = FES_P_PEND;
                end
            end
            FES_P_PEND: begin
                if (prog_exp) begin
                    state_next = es_reg ? FES_E_SUSP : FES_IDLE;
                end else if (lat_exp) begin
                    state_next = FES_P_SUSP;
                end
            end
            FES_P_SUSP: begin
                if (program_continue_cmd_go) begin
                    state_next = FES_PROG;
                end
            end
            default: state_next = FES_IDLE;
        endcase
    end

    wire es_next  = (pp_go && st_esusp) || (es_reg && !(prog_live && prog_exp));
    wire wel_next = write_enable_cmd_go || (write_enable_latch_reg && !(se_try || be_try || pp_try || regw_go || ppbe_go));
    assign esector_next = se_go ? f_sector : (be_go ? 8'h00 : (bulk_adv ? o_erase_sector + 8'h01 : o_erase_sector));

    // Hardware sets beat a clear arriving in the same cycle
    always_comb begin
        status_next.erase_err              = se_fail || (o_status.erase_err && !clsr_go);
        status_next.prog_err               = pp_fail || (o_status.prog_err && !clsr_go);
        status_next.erase_paused           = (state_next == FES_E_SUSP) || es_next;
        status_next.prog_paused            = state_next == FES_P_SUSP;
        status_next.write_enable_latch     = wel_next;
        status_next.write_in_progress_flag = (state_next == FES_ERASE) || (state_next == FES_E_PEND)
                                             || (state_next == FES_PROG) || (state_next == FES_P_PEND);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg              <= FES_IDLE;
            write_enable_latch_reg <= 1'b0;
            es_reg                 <= 1'b0;
            bank_armed_reg         <= 1'b0;
            erase_chk_reg          <= 1'b0;
            o_status               <= '0;
            o_erase_run            <= 1'b0;
            o_erase_all            <= 1'b0;
            o_erase_sector         <= 8'h00;
            o_prog_run             <= 1'b0;
        end else begin
            state_reg              <= state_next;
            write_enable_latch_reg <= wel_next;
            es_reg                 <= es_next;
            erase_chk_reg          <= be_go | bulk_adv;
            o_status               <= status_next;
            o_erase_run            <= (state_next == FES_ERASE) || (state_next == FES_E_PEND);
            o_prog_run             <= (state_next == FES_PROG) || (state_next == FES_P_PEND);
            o_erase_sector         <= esector_next;
            if (frm_valid_reg) begin
                bank_armed_reg <= bank_access_cmd_cmd;
            end
            if (se_go || be_go) begin
                o_erase_all <= be_go;
            end
        end
    end

    // Side outputs towards the array, bank and protection logic
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_query_sector <= 8'h00;
            o_prog_addr    <= 32'h00000000;
            o_bank_addr    <= `FES_BANK_RESET;
            o_reg_write    <= 1'b0;
            o_reg_data     <= 8'h00;
            o_lock_erase   <= 1'b0;
        end else begin
            o_reg_write  <= regw_go;
            o_lock_erase <= ppbe_go;
            if (be_go || bulk_adv) begin
                o_query_sector <= esector_next;
            end else if (cs_rise && !(o_erase_all && erase_live)) begin
                o_query_sector <= addr_reg[`FES_SECT_MSB:`FES_SECT_LSB];
            end
            if (pp_go) begin
                o_prog_addr <= frm_reg.addr;
            end
            if (bank_go) begin
                o_bank_addr <= frm_reg.data;
            end
            if (regw_go) begin
                o_reg_data <= frm_reg.data;
            end
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_erase_pause;
        erase_pause_cmd_go ##1 st_epend;
    endsequence

    sequence s_prog_continue;
        program_continue_cmd_go ##1 st_prog;
    endsequence

    AST_PAUSE_ONLY_PROG: assert property (
        (f_exact8 && frm_reg.op == `FES_OP_PROGRAM_PAUSE && (st_idle || st_esusp || st_psusp))
        |=> state_reg == $past(state_reg))
        else $error("program pause acted outside programming");

    AST_PENDING_DEAF: assert property (
        (st_ppend || st_epend) |-> !(pp_go || se_go || be_go || write_enable_cmd_go || regw_go || erase_continue_cmd_go || program_continue_cmd_go))
        else $error("command taken while pause pending");

    AST_PROG_PAUSE_SHOWN: assert property (
        (st_ppend && lat_exp && !prog_exp) |=> (o_status.prog_paused && !o_status.write_in_progress_flag))
        else $error("program pause not reported");

    AST_CONTINUE_IGNORED: assert property (
        (f_exact8 && frm_reg.op == `FES_OP_PROGRAM_CONTINUE && st_idle)
        |=> (st_idle && !o_status.write_in_progress_flag))
        else $error("stray program continue acted");

    AST_CONTINUE_BUSY: assert property (
        s_prog_continue |-> (o_status.write_in_progress_flag && o_prog_run && !o_status.prog_paused))
        else $error("program continue did not set busy");

    AST_WIPE_FRAME_EXACT: assert property (
        (frm_valid_reg && frm_reg.op == `FES_OP_SECTOR_WIPE_LONG && frm_reg.bits != `FES_ADDR32_END && st_idle)
        |=> !o_erase_run)
        else $error("sector wipe started on bad frame");

    AST_ERASE_BUSY: assert property (
        se_go |=> (o_erase_run && o_status.write_in_progress_flag) [*2])
        else $error("erase running without busy");

    AST_PROTECTED_WIPE: assert property (
        se_fail |=> (o_status.erase_err && !o_erase_run))
        else $error("protected sector wipe not flagged");

    AST_ARRAY_PROTECT_DROP: assert property (
        (be_try && i_block_protect != 3'h0)
        |=> (!o_erase_run && o_status.erase_err == $past(o_status.erase_err)))
        else $error("array wipe ran under block protect");

    AST_ERASE_PAUSE_LATENCY: assert property (
        s_erase_pause |-> ##[0:ESL_BOUND] !st_epend)
        else $error("erase pause exceeded latency");

    AST_ARRAY_NO_PAUSE: assert property (
        (st_erase && o_erase_all) |=> !st_epend)
        else $error("array wipe accepted a pause");

    AST_LOCKED_PROG_FAILS: assert property (
        (pp_try && st_esusp && o_query_sector == o_erase_sector) |=> (o_status.prog_err && st_esusp))
        else $error("program in paused sector not failed");

    AST_ERASE_CONTINUE_IGNORED: assert property (
        (f_exact8 && frm_reg.op == `FES_OP_ERASE_CONTINUE && st_idle) |=> !o_erase_run)
        else $error("stray erase continue acted");

    AST_REGWRITE_REFUSED: assert property (
        (wrr_cmd && st_esusp && !bank_armed_reg) |=> !o_reg_write)
        else $error("register write passed during erase pause");

endmodule : fes_sequencer
`default_nettype wire

/* verification/fes_host_model.sv */
// Host controller model that frames serial commands toward the sequencer
`timescale 1ns/1ps
`default_nettype none
module fes_host_model (
    input  wire logic i_clk,
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_si
);
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_si   = 1'b0;
    end

    // Sends the first n bits of v, msb first; sck held low two clocks and high three clocks per bit, two for the last bit
    task automatic send(input logic [39:0] v, input int n);
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            o_si  <= v[39-i];
            o_sck <= 1'b0;
            repeat (2) @(posedge i_clk);
            o_sck <= 1'b1;
            repeat (2) @(posedge i_clk);
        end
        o_sck  <= 1'b0;
        @(posedge i_clk);
        o_cs_n <= 1'b1;
        // Released data line must not look like a held bit
        o_si   <= ~o_si;
        repeat (6) @(posedge i_clk);
    endtask : send
endmodule : fes_host_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the erase and suspend sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fes_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        cs_n;
    logic        sck;
    logic        si;
    logic        long_sel = 1'b0;
    logic [2:0]  bp = 3'h0;
    logic        bp_hit = 1'b0;
    fes_status_t st;
    logic [7:0]  bank;
    int          n_mismatch = 0;
    int          n_tests = 0;

    always #25 i_clk = ~i_clk;

    fes_sequencer #(.ERASE_CYCLES(3000), .PROG_CYCLES(2000)) fes_sequencer_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
        .i_long_address_select(long_sel), .i_block_protect(bp),
        .i_block_protect_hit(bp_hit), .i_sector_lock_hit(1'b0), .o_status(st),
        .o_query_sector(), .o_erase_run(), .o_erase_all(), .o_erase_sector(),
        .o_prog_run(), .o_prog_addr(), .o_bank_addr(bank), .o_reg_write(),
        .o_reg_data(), .o_lock_erase()
    );

    fes_host_model fes_host_model_inst (.i_clk(i_clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: value %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Bounded wait for busy to drop
    task automatic wait_idle(input int lim);
        for (int k = 0; k < lim && st.write_in_progress_flag !== 1'b0; k++) @(posedge i_clk);
        @(posedge i_clk);
    endtask : wait_idle

    task automatic write_enable_cmd();
        fes_host_model_inst.send({8'h06, 32'h0}, 8);
    endtask : write_enable_cmd

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    initial begin
        // About 40000 clocks, well above the few thousand the tests need
        #2000000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        fes_host_model_inst.send({8'hd8, 32'h0}, 32);
        check(st.write_in_progress_flag, 1'b0);
        fes_host_model_inst.send({8'h8a, 32'h0}, 8);
        check(st.write_in_progress_flag, 1'b0);
        write_enable_cmd();
        check(st.write_enable_latch, 1'b1);
        fes_host_model_inst.send({8'hd8, 32'h0}, 40);
        check(st.write_in_progress_flag, 1'b0);
        fes_host_model_inst.send({8'hd8, 32'h0}, 32);
        check(st.write_in_progress_flag, 1'b1);
        fes_host_model_inst.send({8'h75, 32'h0}, 8);
        check(st.write_in_progress_flag, 1'b1);
        // Only waiting here, no other command while the pause lands
        wait_idle(1200);
        check(st.erase_paused, 1'b1);
        fes_host_model_inst.send({8'h7a, 32'h0}, 8);
        check({st.write_in_progress_flag, st.erase_paused}, 2'b10);
        wait_idle(3500);
        check({st.write_in_progress_flag, st.erase_paused}, 2'b00);
        fes_host_model_inst.send({8'h7a, 32'h0}, 8);
        check(st.write_in_progress_flag, 1'b0);
        $display("erase pause test done");
        write_enable_cmd();
        fes_host_model_inst.send({8'h02, 24'h000100, 8'ha5}, 40);
        check(st.write_in_progress_flag, 1'b1);
        fes_host_model_inst.send({8'h85, 32'h0}, 8);
        wait_idle(1200);
        check(st.prog_paused, 1'b1);
        fes_host_model_inst.send({8'h8a, 32'h0}, 8);
        check({st.write_in_progress_flag, st.prog_paused}, 2'b10);
        wait_idle(2500);
        check(st.prog_paused, 1'b0);
        $display("program pause test done");
        bp <= 3'h1;
        write_enable_cmd();
        fes_host_model_inst.send({8'h60, 32'h0}, 8);
        check({st.write_in_progress_flag, st.erase_err}, 2'b00);
        bp <= 3'h0;
        write_enable_cmd();
        fes_host_model_inst.send({8'hc7, 32'h0}, 16);
        check(st.write_in_progress_flag, 1'b0);
        bp_hit <= 1'b1;
        write_enable_cmd();
        fes_host_model_inst.send({8'hd8, 32'h0}, 32);
        check({st.write_in_progress_flag, st.erase_err}, 2'b01);
        bp_hit <= 1'b0;
        fes_host_model_inst.send({8'hb9, 32'h0}, 8);
        fes_host_model_inst.send({8'h01, 8'h5a, 24'h0}, 16);
        check(bank, 8'h5a);
        fes_host_model_inst.send({8'h30, 32'h0}, 8);
        check(st.erase_err, 1'b0);
        $display("protection test done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
